// [core/dpllrc_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef DPLLRC_MAP_SVH
`define DPLLRC_MAP_SVH
`define DPLLRC_ADDR_W 11
`define DPLLRC_OFS_CR1 11'h071
`define DPLLRC_OFS_CR2 11'h072
`define DPLLRC_OFS_CR3 11'h073
`define DPLLRC_OFS_CR4 11'h074
`define DPLLRC_OFS_CR5 11'h075
`define DPLLRC_OFS_CR6 11'h076
`define DPLLRC_OFS_STAT 11'h07E
`define DPLLRC_OFS_AUX 11'h205
`define DPLLRC_RST_CR1 8'h00
`define DPLLRC_RST_CR2 8'h00
`define DPLLRC_RST_CR3 8'h6F
`define DPLLRC_RST_CR4 8'h6D
`define DPLLRC_RST_CR5 8'h70
`define DPLLRC_RST_CR6 8'hE0
`define DPLLRC_RST_AUX 8'h00
`define DPLLRC_B_PINSW 7
`define DPLLRC_B_ULTRA_FAST_SWITCH 6
`define DPLLRC_B_REVERTIVE_ENABLE 5
`define DPLLRC_B_WIDE 4
`define DPLLRC_B_HOLDOVER_HISTORY_CLEAR 3
`define DPLLRC_B_NO_ACTIVITY_LOCK_LOSS 7
`define DPLLRC_B_FREQ_LIMIT_LOCK_LOSS 6
`define DPLLRC_B_AUTO_BANDWIDTH_SEL 7
`define DPLLRC_B_AUXHO 0
`define DPLLRC_BW_MAX 5'h14
`define DPLLRC_DAMP_MIN 3'h1
`define DPLLRC_DAMP_MAX 3'h5
`define DPLLRC_CLK_MHZ 200
`define DPLLRC_LOCK_TIME_US 100
`define DPLLRC_LOCK_CYC (`DPLLRC_LOCK_TIME_US * `DPLLRC_CLK_MHZ)
`define DPLLRC_MINI_HOLDOVER_MODE_SEL_TIME_US 10
`define DPLLRC_MINI_HOLDOVER_MODE_SEL_CYC (`DPLLRC_MINI_HOLDOVER_MODE_SEL_TIME_US * `DPLLRC_CLK_MHZ)
`define DPLLRC_REF_PERIOD_CYC 16'h0010
`define DPLLRC_NOACT_PERIODS 2
`define DPLLRC_UF_MISS 3
`define DPLLRC_SLOW_MISS 8
`endif

// [core/dpllrc_pkg.sv]
// Types shared by the loop control block
package dpllrc_pkg;
   typedef enum logic [1:0] {SEL_NONE, SEL_ONE, SEL_TWO} dpllrc_ref_e;
   typedef enum {ST_FREE, ST_HOLD, ST_LOCKED, ST_PRE2, ST_PRE, ST_LOSS, ST_MINI} dpllrc_state_e;
   typedef struct packed {
      logic active;
      logic valid;
   } dpllrc_mon_s;
   typedef struct packed {
      logic [1:0] force_code;
      logic revertive_enable;
      logic pin_switch_mode;
      logic select_pin;
      logic loop_enable;
   } dpllrc_selcfg_s;
endpackage

// [core/dpllrc_act_mon.sv]
// Activity and validity monitor for one input reference clock
`timescale 1ns/1ps
`include "dpllrc_map.svh"
`default_nettype none
module dpllrc_act_mon (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ref_clk_in,
   input wire logic freq_ok,
   input wire logic ultra_fast_switch,
   output dpllrc_pkg::dpllrc_mon_s mon
);
   import dpllrc_pkg::*;

   function automatic logic [15:0] periods(input logic [3:0] n);
      periods = 16'(`DPLLRC_REF_PERIOD_CYC * n);
   endfunction

   logic prev_reg, prev_next;
   logic seen_reg, seen_next;
   logic [15:0] gap_reg, gap_next;
   dpllrc_mon_s mon_reg, mon_next;
   logic edge_hit;
   logic [15:0] miss_lim;

   always_comb
   begin
      edge_hit = ref_clk_in && !prev_reg;
      prev_next = ref_clk_in;
      seen_next = seen_reg || edge_hit;
      gap_next = edge_hit ? 16'h0000 : ((gap_reg == 16'hFFFF) ? gap_reg : gap_reg + 16'h0001);
      miss_lim = ultra_fast_switch ? periods(4'(`DPLLRC_UF_MISS)) : periods(4'(`DPLLRC_SLOW_MISS));
      mon_next.active = seen_next && (gap_next < periods(4'(`DPLLRC_NOACT_PERIODS)));
      mon_next.valid = seen_next && freq_ok && (gap_next < miss_lim);
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prev_reg <= 1'b0;
         seen_reg <= 1'b0;
         gap_reg <= 16'h0000;
         mon_reg <= '0;
      end
      else
      begin
         prev_reg <= prev_next;
         seen_reg <= seen_next;
         gap_reg <= gap_next;
         mon_reg <= mon_next;
      end
   end

   assign mon = mon_reg;
endmodule
`default_nettype wire

// [core/dpllrc_ref_sel.sv]
// Reference selection and priority table
`timescale 1ns/1ps
`include "dpllrc_map.svh"
`default_nettype none
module dpllrc_ref_sel (
   input wire logic clk,
   input wire logic sys_rst,
   input wire dpllrc_pkg::dpllrc_selcfg_s cfg,
   input wire logic [1:0] ref_valid,
   output dpllrc_pkg::dpllrc_ref_e selected_reference,
   output dpllrc_pkg::dpllrc_ref_e top_priority_ref
);
   import dpllrc_pkg::*;

   function automatic logic is_valid(input dpllrc_ref_e r, input logic [1:0] v);
      is_valid = (r == SEL_ONE) ? v[0] : ((r == SEL_TWO) ? v[1] : 1'b0);
   endfunction

   dpllrc_ref_e sel_reg, sel_next, top_reg, top_next;
   dpllrc_ref_e first, second, forced, best;
   logic cur_ok;

   always_comb
   begin
      forced = SEL_NONE;
      if (cfg.force_code == 2'h1)
         forced = SEL_ONE;
      else if (cfg.force_code == 2'h2)
         forced = SEL_TWO;
      first = (forced == SEL_TWO) ? SEL_TWO : SEL_ONE;
      second = (first == SEL_ONE) ? SEL_TWO : SEL_ONE;
      best = is_valid(first, ref_valid) ? first : (is_valid(second, ref_valid) ? second : SEL_NONE);
      cur_ok = is_valid(sel_reg, ref_valid);
      sel_next = sel_reg;
      top_next = (forced != SEL_NONE) ? forced : ((best != SEL_NONE) ? best : top_reg);
      if (!cfg.loop_enable)
      begin
         sel_next = SEL_NONE;
         top_next = SEL_ONE;
      end
      else if (cfg.pin_switch_mode)
      begin
         sel_next = cfg.select_pin ? SEL_ONE : SEL_TWO;
         top_next = sel_next;
      end
      else if (forced != SEL_NONE)
      begin
         if (cfg.revertive_enable || !cur_ok)
            sel_next = forced;
      end
      else if (cfg.revertive_enable)
      begin
         if (best != SEL_NONE)
            sel_next = best;
      end
      else if (!cur_ok && best != SEL_NONE)
         sel_next = best;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sel_reg <= SEL_NONE;
         top_reg <= SEL_ONE;
      end
      else
      begin
         sel_reg <= sel_next;
         top_reg <= top_next;
      end
   end

   assign selected_reference = sel_reg;
   assign top_priority_ref = top_reg;
endmodule
`default_nettype wire

// [core/dpllrc_top.sv]
// Loop reference and state control with its configuration registers
`timescale 1ns/1ps
`include "dpllrc_map.svh"
`default_nettype none
module dpllrc_top #(
   parameter int unsigned LOCK_CYC = `DPLLRC_LOCK_CYC,
   parameter int unsigned MINI_HOLDOVER_MODE_SEL_CYC = `DPLLRC_MINI_HOLDOVER_MODE_SEL_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`DPLLRC_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic master_clock_present,
   input wire logic loop_global_enable,
   input wire logic pin_switch_strap,
   input wire logic select_pin,
   input wire logic input_clock_one,
   input wire logic input_clock_two,
   input wire logic [1:0] ref_freq_ok,
   input wire logic freq_over_limit,
   input wire logic fast_avg_done,
   input wire logic slow_avg_done,
   output dpllrc_pkg::dpllrc_ref_e selected_reference,
   output dpllrc_pkg::dpllrc_ref_e top_priority_ref,
   output logic [2:0] loop_state_code,
   output logic [4:0] active_bandwidth,
   output logic [2:0] active_damping,
   output logic wide_tracking_range,
   output logic [1:0] holdover_src,
   output logic holdover_history_clear,
   output logic fast_holdover_ready,
   output logic slow_holdover_ready,
   output logic full_phase_lock
);
   import dpllrc_pkg::*;

   function automatic logic [2:0] state_code(input dpllrc_state_e s);
      case (s)
         ST_FREE: state_code = 3'h1;
         ST_HOLD: state_code = 3'h2;
         ST_MINI: state_code = 3'h2;
         ST_LOCKED: state_code = 3'h4;
         ST_PRE2: state_code = 3'h5;
         ST_PRE: state_code = 3'h6;
         ST_LOSS: state_code = 3'h7;
         default: state_code = 3'h1;
      endcase
   endfunction

   function automatic logic [4:0] bw_clip(input logic [4:0] code, input logic [4:0] dflt);
      bw_clip = (code > `DPLLRC_BW_MAX) ? dflt : code;
   endfunction

   function automatic logic [2:0] damp_clip(input logic [2:0] code);
      damp_clip = (code < `DPLLRC_DAMP_MIN || code > `DPLLRC_DAMP_MAX) ? 3'h3 : code;
   endfunction

   // Configuration registers
   logic [7:0] cr1_reg, cr1_next, cr2_reg, cr2_next, cr3_reg, cr3_next;
   logic [7:0] cr4_reg, cr4_next, cr5_reg, cr5_next, cr6_reg, cr6_next;
   logic [7:0] aux_reg, aux_next, rdata_reg, rdata_next, stat_byte;
   logic strap_done_reg, strap_done_next;
   logic acc_ok;

   always_comb
   begin
      acc_ok = master_clock_present;
      cr1_next = cr1_reg;
      cr2_next = cr2_reg;
      cr3_next = cr3_reg;
      cr4_next = cr4_reg;
      cr5_next = cr5_reg;
      cr6_next = cr6_reg;
      aux_next = aux_reg;
      strap_done_next = 1'b1;
      if (!strap_done_reg)
         cr1_next[`DPLLRC_B_PINSW] = pin_switch_strap;
      if (reg_wr && acc_ok)
      begin
         case (reg_addr)
            `DPLLRC_OFS_CR1: cr1_next = reg_wdata;
            `DPLLRC_OFS_CR2: cr2_next = reg_wdata;
            `DPLLRC_OFS_CR3: cr3_next = reg_wdata;
            `DPLLRC_OFS_CR4: cr4_next = reg_wdata;
            `DPLLRC_OFS_CR5: cr5_next = reg_wdata;
            `DPLLRC_OFS_CR6: cr6_next = reg_wdata;
            `DPLLRC_OFS_AUX: aux_next = reg_wdata;
            default: cr1_next = cr1_next;
         endcase
      end
      rdata_next = 8'h00;
      if (reg_rd && acc_ok)
      begin
         case (reg_addr)
            `DPLLRC_OFS_CR1: rdata_next = cr1_reg;
            `DPLLRC_OFS_CR2: rdata_next = cr2_reg;
            `DPLLRC_OFS_CR3: rdata_next = cr3_reg;
            `DPLLRC_OFS_CR4: rdata_next = cr4_reg;
            `DPLLRC_OFS_CR5: rdata_next = cr5_reg;
            `DPLLRC_OFS_CR6: rdata_next = cr6_reg;
            `DPLLRC_OFS_AUX: rdata_next = aux_reg;
            `DPLLRC_OFS_STAT: rdata_next = stat_byte;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cr1_reg <= `DPLLRC_RST_CR1;
         cr2_reg <= `DPLLRC_RST_CR2;
         cr3_reg <= `DPLLRC_RST_CR3;
         cr4_reg <= `DPLLRC_RST_CR4;
         cr5_reg <= `DPLLRC_RST_CR5;
         cr6_reg <= `DPLLRC_RST_CR6;
         aux_reg <= `DPLLRC_RST_AUX;
         rdata_reg <= 8'h00;
         strap_done_reg <= 1'b0;
      end
      else
      begin
         cr1_reg <= cr1_next;
         cr2_reg <= cr2_next;
         cr3_reg <= cr3_next;
         cr4_reg <= cr4_next;
         cr5_reg <= cr5_next;
         cr6_reg <= cr6_next;
         aux_reg <= aux_next;
         rdata_reg <= rdata_next;
         strap_done_reg <= strap_done_next;
      end
   end

   // Input monitors and selection
   dpllrc_mon_s mon_one, mon_two;
   dpllrc_selcfg_s sel_cfg;
   dpllrc_ref_e sel_ref;
   logic uf_en;

   assign uf_en = loop_global_enable && cr1_reg[`DPLLRC_B_ULTRA_FAST_SWITCH];

   dpllrc_act_mon u_mon_one (
      .clk(clk),
      .sys_rst(sys_rst),
      .ref_clk_in(input_clock_one),
      .freq_ok(ref_freq_ok[0]),
      .ultra_fast_switch(uf_en),
      .mon(mon_one)
   );

   dpllrc_act_mon u_mon_two (
      .clk(clk),
      .sys_rst(sys_rst),
      .ref_clk_in(input_clock_two),
      .freq_ok(ref_freq_ok[1]),
      .ultra_fast_switch(uf_en),
      .mon(mon_two)
   );

   always_comb
   begin
      sel_cfg.force_code = (cr1_reg[3:2] == 2'h0) ? cr1_reg[1:0] : 2'h0;
      sel_cfg.revertive_enable = cr1_reg[`DPLLRC_B_REVERTIVE_ENABLE];
      sel_cfg.pin_switch_mode = cr1_reg[`DPLLRC_B_PINSW];
      sel_cfg.select_pin = select_pin;
      sel_cfg.loop_enable = loop_global_enable;
   end

   dpllrc_ref_sel u_sel (
      .clk(clk),
      .sys_rst(sys_rst),
      .cfg(sel_cfg),
      .ref_valid({mon_two.valid, mon_one.valid}),
      .selected_reference(sel_ref),
      .top_priority_ref(top_priority_ref)
   );
   assign selected_reference = sel_ref;

   // Loop state machine
   dpllrc_state_e st_reg, st_next;
   logic [31:0] tmr_reg, tmr_next;
   logic sel_act, ref_ok, lol_evt;

   always_comb
   begin
      sel_act = (sel_ref == SEL_ONE) ? mon_one.active : ((sel_ref == SEL_TWO) ? mon_two.active : 1'b0);
      ref_ok = (sel_ref == SEL_ONE) ? mon_one.valid : ((sel_ref == SEL_TWO) ? mon_two.valid : 1'b0);
      if (cr1_reg[`DPLLRC_B_PINSW])
         ref_ok = sel_act;
      lol_evt = (cr5_reg[`DPLLRC_B_NO_ACTIVITY_LOCK_LOSS] && !sel_act)
         || (cr5_reg[`DPLLRC_B_FREQ_LIMIT_LOCK_LOSS] && freq_over_limit);
      st_next = st_reg;
      case (st_reg)
         ST_FREE: if (ref_ok) st_next = ST_PRE;
         ST_PRE, ST_PRE2:
            if (!ref_ok)
               st_next = ST_MINI;
            else if (lol_evt)
               st_next = ST_LOSS;
            else if (tmr_reg >= LOCK_CYC)
               st_next = ST_LOCKED;
         ST_LOCKED:
            if (!ref_ok)
               st_next = ST_MINI;
            else if (lol_evt)
               st_next = ST_LOSS;
         ST_MINI:
            if (ref_ok)
               st_next = ST_PRE2;
            else if (tmr_reg >= MINI_HOLDOVER_MODE_SEL_CYC)
               st_next = ST_HOLD;
         ST_HOLD: if (ref_ok) st_next = ST_PRE2;
         ST_LOSS:
            if (!ref_ok)
               st_next = ST_MINI;
            else if (!lol_evt)
               st_next = ST_PRE;
         default: st_next = ST_FREE;
      endcase
      case (cr2_reg[2:0])
         3'h1: st_next = ST_FREE;
         3'h2: st_next = ST_HOLD;
         3'h4: st_next = ST_LOCKED;
         3'h5: st_next = ST_PRE2;
         3'h6: st_next = ST_PRE;
         3'h7: st_next = ST_LOSS;
         default: st_next = st_next;
      endcase
      if (!loop_global_enable)
         st_next = ST_FREE;
      tmr_next = (st_next != st_reg) ? 32'h0 : ((tmr_reg == 32'hFFFFFFFF) ? tmr_reg : tmr_reg + 32'h1);
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_reg <= ST_FREE;
         tmr_reg <= 32'h0;
      end
      else
      begin
         st_reg <= st_next;
         tmr_reg <= tmr_next;
      end
   end

   // Loop control outputs
   logic [2:0] code_reg, code_next, damp_reg, damp_next;
   logic [4:0] bw_reg, bw_next;
   logic [1:0] hsrc_reg, hsrc_next;
   logic wide_reg, wide_next, holdover_history_clear_prev_reg, holdover_history_clear_prev_next, clr_reg, clr_next;
   logic frdy_reg, frdy_next, srdy_reg, srdy_next, full_reg, full_next;
   logic use_lock;

   always_comb
   begin
      use_lock = (st_reg == ST_LOCKED) || !cr6_reg[`DPLLRC_B_AUTO_BANDWIDTH_SEL];
      bw_next = use_lock ? bw_clip(cr4_reg[4:0], 5'h0D) : bw_clip(cr3_reg[4:0], 5'h0F);
      damp_next = use_lock ? damp_clip(cr4_reg[7:5]) : damp_clip(cr3_reg[7:5]);
      if (use_lock)
         bw_next = bw_clip(cr4_reg[4:0], 5'h0D);
      wide_next = cr1_reg[`DPLLRC_B_WIDE];
      hsrc_next = 2'h0;
      if (aux_reg[`DPLLRC_B_AUXHO])
         hsrc_next = (st_reg == ST_MINI) ? cr2_reg[5:4] : cr2_reg[7:6];
      holdover_history_clear_prev_next = cr2_reg[`DPLLRC_B_HOLDOVER_HISTORY_CLEAR];
      clr_next = cr2_reg[`DPLLRC_B_HOLDOVER_HISTORY_CLEAR] && !holdover_history_clear_prev_reg;
      frdy_next = fast_avg_done ? 1'b1 : (clr_next ? 1'b0 : frdy_reg);
      srdy_next = slow_avg_done ? 1'b1 : (clr_next ? 1'b0 : srdy_reg);
      full_next = (st_reg == ST_LOSS);
      code_next = (cr2_reg[2:0] != 3'h0) ? cr2_reg[2:0] : state_code(st_reg);
      if (!loop_global_enable)
      begin
         code_next = 3'h1;
         bw_next = 5'h0D;
         damp_next = 3'h3;
         wide_next = 1'b0;
         hsrc_next = 2'h0;
         clr_next = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         code_reg <= 3'h1;
         bw_reg <= 5'h0D;
         damp_reg <= 3'h3;
         hsrc_reg <= 2'h0;
         wide_reg <= 1'b0;
         holdover_history_clear_prev_reg <= 1'b0;
         clr_reg <= 1'b0;
         frdy_reg <= 1'b0;
         srdy_reg <= 1'b0;
         full_reg <= 1'b0;
      end
      else
      begin
         code_reg <= code_next;
         bw_reg <= bw_next;
         damp_reg <= damp_next;
         hsrc_reg <= hsrc_next;
         wide_reg <= wide_next;
         holdover_history_clear_prev_reg <= holdover_history_clear_prev_next;
         clr_reg <= clr_next;
         frdy_reg <= frdy_next;
         srdy_reg <= srdy_next;
         full_reg <= full_next;
      end
   end

   assign stat_byte = {frdy_reg, srdy_reg, sel_ref, full_reg, code_reg};
   assign reg_rdata = rdata_reg;
   assign loop_state_code = code_reg;
   assign active_bandwidth = bw_reg;
   assign active_damping = damp_reg;
   assign wide_tracking_range = wide_reg;
   assign holdover_src = hsrc_reg;
   assign holdover_history_clear = clr_reg;
   assign fast_holdover_ready = frdy_reg;
   assign slow_holdover_ready = srdy_reg;
   assign full_phase_lock = full_reg;
endmodule
`default_nettype wire

// [test/dpllrc_monitor.sv]
// Concurrent checks on the loop control block ports
`timescale 1ns/1ps
`default_nettype none
`include "dpllrc_map.svh"
module dpllrc_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`DPLLRC_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic master_clock_present,
   input wire logic loop_global_enable,
   input wire logic select_pin,
   input wire logic freq_over_limit,
   input wire logic fast_avg_done,
   input wire logic slow_avg_done,
   input wire dpllrc_pkg::dpllrc_ref_e selected_reference,
   input wire logic [2:0] loop_state_code,
   input wire logic [4:0] active_bandwidth,
   input wire logic wide_tracking_range,
   input wire logic holdover_history_clear,
   input wire logic fast_holdover_ready,
   input wire logic slow_holdover_ready
);
   import dpllrc_pkg::*;
   logic [6:1][7:0] cr_reg;
   logic [6:1][7:0] cr_next;
   logic wr_ok;
   logic [4:0] exp_lbw;
   assign wr_ok = reg_wr && master_clock_present;
   assign exp_lbw = (cr_reg[4][4:0] > `DPLLRC_BW_MAX) ? 5'h0D : cr_reg[4][4:0];
   // Mirror of the configuration bytes
   always_comb
   begin
      cr_next = cr_reg;
      if (wr_ok && reg_addr >= `DPLLRC_OFS_CR1 && reg_addr <= `DPLLRC_OFS_CR6)
         cr_next[reg_addr[2:0]] = reg_wdata;
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         cr_reg <= {`DPLLRC_RST_CR6, `DPLLRC_RST_CR5, `DPLLRC_RST_CR4, `DPLLRC_RST_CR3, `DPLLRC_RST_CR2, `DPLLRC_RST_CR1};
      else
         cr_reg <= cr_next;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero while idle");
   a_read_blocked_noclk: assert property (reg_rd && !master_clock_present |=> reg_rdata == 8'h00)
      else $error("read answered without master clock");
   a_pin_sel_one: assert property ((loop_global_enable && cr_reg[1][7] && select_pin && $stable(cr_reg[1]))[*4]
      |-> selected_reference == SEL_ONE) else $error("pin high did not select input one");
   a_pin_sel_two: assert property ((loop_global_enable && cr_reg[1][7] && !select_pin && $stable(cr_reg[1]))[*4]
      |-> selected_reference == SEL_TWO) else $error("pin low did not select input two");
   a_state_held: assert property ((loop_global_enable && cr_reg[2][2:0] != 3'h0 && cr_reg[2][2:0] != 3'h3
      && $stable(cr_reg[2][2:0]))[*4] |-> loop_state_code == cr_reg[2][2:0]) else $error("forced state not held");
   a_holdover_history_clear_pulse_one: assert property (holdover_history_clear |=> !holdover_history_clear)
      else $error("history clear longer than one cycle");
   a_holdover_history_clear_on_rise: assert property (wr_ok && reg_addr == `DPLLRC_OFS_CR2 && reg_wdata[3] && !cr_reg[2][3]
      |-> ##[1:3] holdover_history_clear) else $error("history clear missing after rising bit");
   a_holdover_history_clear_clears_ready: assert property (holdover_history_clear && !fast_avg_done && !slow_avg_done
      |-> ##[0:2] (!fast_holdover_ready && !slow_holdover_ready)) else $error("ready flags not cleared");
   a_lock_bw_used: assert property ((loop_global_enable && (!cr_reg[6][7] || loop_state_code == 3'h4)
      && $stable(cr_reg[4]) && $stable(cr_reg[6]))[*4] |-> active_bandwidth == exp_lbw) else $error("locked bandwidth not used");
   a_wide_follows_bit: assert property ((loop_global_enable && $stable(cr_reg[1][4]))[*3]
      |-> wide_tracking_range == cr_reg[1][4]) else $error("tracking range bit not followed");
   a_freq_limit_loss: assert property (loop_global_enable && cr_reg[2][2:0] == 3'h0 && cr_reg[5][6]
      && freq_over_limit && loop_state_code == 3'h4 |-> ##[1:4] loop_state_code == 3'h7) else $error("no loss of lock at limit");
   a_disabled_idle: assert property ((!loop_global_enable)[*4]
      |-> selected_reference == SEL_NONE && loop_state_code == 3'h1) else $error("disabled loop still active");
endmodule
`default_nettype wire

// [test/dpllrc_ref_model.sv]
// Reference clock and select pin source for the loop control bench
`timescale 1ns/1ps
`default_nettype none
module dpllrc_ref_model (
   input wire logic clk,
   input wire logic [1:0] run,
   input wire logic pin_level,
   output logic input_clock_one,
   output logic input_clock_two,
   output logic select_pin
);
   logic [3:0] phase_reg;
   initial phase_reg = 4'h0;
   always @(negedge clk)
      phase_reg <= phase_reg + 4'h1;
   // Sixteen-cycle period, held low while stopped
   assign input_clock_one = run[0] && phase_reg[3];
   assign input_clock_two = run[1] && !phase_reg[3];
   assign select_pin = pin_level;
endmodule
`default_nettype wire

// [test/tb_dpllrc_top.sv]
// Self-checking bench for the loop control block
`timescale 1ns/1ps
`default_nettype none
`include "dpllrc_map.svh"
module tb_dpllrc_top;
   import dpllrc_pkg::*;
   logic clk, sys_rst, reg_wr, reg_rd, master_clock_present, loop_global_enable, pin_switch_strap, select_pin;
   logic [`DPLLRC_ADDR_W-1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, v;
   logic [1:0] run, ref_freq_ok, holdover_src;
   logic pin_level, freq_over_limit, fast_avg_done, slow_avg_done, input_clock_one, input_clock_two, rd_d;
   dpllrc_ref_e selected_reference, top_priority_ref;
   logic [2:0] loop_state_code, active_damping;
   logic [4:0] active_bandwidth;
   logic wide_tracking_range, holdover_history_clear, fast_holdover_ready, slow_holdover_ready, full_phase_lock;
   int fail_count = 0, comparisons = 0, cycles = 0, seed;
   logic [7:0] exp_q[$];
   logic [7:0] rst_tab [6] = '{`DPLLRC_RST_CR1, `DPLLRC_RST_CR2, `DPLLRC_RST_CR3, `DPLLRC_RST_CR4,
      `DPLLRC_RST_CR5, `DPLLRC_RST_CR6};
   logic [2:0] st_tab [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
   dpllrc_top #(.LOCK_CYC(50), .MINI_HOLDOVER_MODE_SEL_CYC(60)) dut (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .master_clock_present, .loop_global_enable, .pin_switch_strap, .select_pin, .input_clock_one,
      .input_clock_two, .ref_freq_ok, .freq_over_limit, .fast_avg_done, .slow_avg_done, .selected_reference,
      .top_priority_ref, .loop_state_code, .active_bandwidth, .active_damping, .wide_tracking_range, .holdover_src,
      .holdover_history_clear, .fast_holdover_ready, .slow_holdover_ready, .full_phase_lock);
   dpllrc_ref_model partner (.clk, .run, .pin_level, .input_clock_one, .input_clock_two, .select_pin);
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic tally_and_finish;
      if (fail_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
      cmp_rd(got, exp);
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(negedge clk);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [10:0] a, input logic [7:0] e);
      @(negedge clk);
      {reg_rd, reg_addr} = {1'b1, a};
      exp_q.push_back(e);
      @(negedge clk);
      reg_rd = 1'b0;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Read results land one cycle after the strobe
   always @(posedge clk)
   begin
      if (rd_d === 1'b1 && exp_q.size() > 0)
         cmp_rd(reg_rdata, exp_q.pop_front());
      rd_d <= reg_rd;
      cycles++;
      if (cycles > 4000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial
   begin
      seed = 3235;
      {reg_wr, reg_rd, reg_addr, reg_wdata, pin_switch_strap, freq_over_limit, fast_avg_done, slow_avg_done} = '0;
      {master_clock_present, loop_global_enable, pin_level, run, ref_freq_ok, sys_rst} = 8'b1110_0111;
      wait_cyc(5);
      cmp_out({3'h0, active_bandwidth}, 8'h0D);
      cmp_out({5'h0, active_damping}, 8'h03);
      sys_rst = 1'b0;
      wait_cyc(2);
      foreach (rst_tab[i])
         rd(11'h071 + 11'(i), rst_tab[i]);
      rd(11'h077, 8'h00);
      repeat (4)
      begin
         v = 8'($random(seed));
         wr(11'h073, v);
         rd(11'h073, v);
         wr(11'h074, ~v);
         rd(11'h074, ~v);
      end
      wr(11'h073, 8'h6F);
      wr(11'h074, 8'h6D);
      master_clock_present = 1'b0;
      wr(11'h072, 8'h55);
      rd(11'h072, 8'h00);
      master_clock_present = 1'b1;
      rd(11'h072, 8'h00);
      run = 2'b11;
      wait_cyc(80);
      cmp_out({6'h0, selected_reference}, {6'h0, SEL_ONE});
      wr(11'h071, 8'h22);
      wait_cyc(4);
      cmp_out({4'h0, selected_reference, top_priority_ref}, {4'h0, SEL_TWO, SEL_TWO});
      wr(11'h071, 8'h01);
      wait_cyc(4);
      cmp_out({4'h0, selected_reference, top_priority_ref}, {4'h0, SEL_TWO, SEL_ONE});
      run = 2'b01;
      wait_cyc(200);
      cmp_out({6'h0, selected_reference}, {6'h0, SEL_ONE});
      run = 2'b10;
      wait_cyc(200);
      cmp_out({3'h0, selected_reference, loop_state_code}, {3'h0, SEL_ONE, 3'h2});
      run = 2'b11;
      wr(11'h071, 8'h60);
      wait_cyc(80);
      run = 2'b10;
      wait_cyc(80);
      cmp_out({6'h0, selected_reference}, {6'h0, SEL_TWO});
      run = 2'b11;
      wait_cyc(80);
      cmp_out({6'h0, selected_reference}, {6'h0, SEL_ONE});
      wr(11'h071, 8'h92);
      wait_cyc(6);
      cmp_out({6'h0, selected_reference}, {6'h0, SEL_ONE});
      cmp_out({7'h0, wide_tracking_range}, 8'h01);
      pin_level = 1'b0;
      wait_cyc(6);
      cmp_out({6'h0, selected_reference}, {6'h0, SEL_TWO});
      pin_level = 1'b1;
      wr(11'h071, 8'h60);
      foreach (st_tab[i])
      begin
         wr(11'h072, {5'h00, st_tab[i]});
         wait_cyc(4);
         cmp_out({5'h0, loop_state_code}, {5'h0, st_tab[i]});
      end
      wr(11'h072, 8'h06);
      wait_cyc(4);
      cmp_out({3'h0, active_bandwidth}, 8'h0F);
      wr(11'h076, 8'h60);
      wait_cyc(4);
      cmp_out({3'h0, active_bandwidth}, 8'h0D);
      wr(11'h076, 8'hE0);
      wr(11'h072, 8'h00);
      repeat (2)
      begin
         {fast_avg_done, slow_avg_done} = 2'b11;
         wait_cyc(1);
         {fast_avg_done, slow_avg_done} = 2'b00;
         wait_cyc(2);
         cmp_out({6'h0, fast_holdover_ready, slow_holdover_ready}, 8'h03);
         wr(11'h072, 8'h08);
         wait_cyc(3);
      end
      cmp_out({6'h0, fast_holdover_ready, slow_holdover_ready}, 8'h03);
      wr(11'h072, 8'h00);
      wr(11'h072, 8'h08);
      wait_cyc(3);
      cmp_out({6'h0, fast_holdover_ready, slow_holdover_ready}, 8'h00);
      wr(11'h205, 8'h01);
      wr(11'h072, 8'hD0);
      run = 2'b00;
      wait_cyc(70);
      cmp_out({6'h0, holdover_src}, 8'h01);
      wait_cyc(80);
      cmp_out({6'h0, holdover_src}, 8'h03);
      run = 2'b11;
      wait_cyc(150);
      cmp_out({5'h0, loop_state_code}, 8'h04);
      freq_over_limit = 1'b1;
      wait_cyc(4);
      cmp_out({4'h0, full_phase_lock, loop_state_code}, 8'h0F);
      rd(11'h07E, {2'b00, SEL_ONE, 1'b1, 3'h7});
      freq_over_limit = 1'b0;
      loop_global_enable = 1'b0;
      wait_cyc(4);
      cmp_out({3'h0, selected_reference, loop_state_code}, {3'h0, SEL_NONE, 3'h1});
      {sys_rst, pin_switch_strap} = 2'b11;
      wait_cyc(2);
      sys_rst = 1'b0;
      wait_cyc(2);
      rd(11'h071, 8'h80);
      wait_cyc(2);
      tally_and_finish();
   end
endmodule
bind dpllrc_top dpllrc_monitor mon (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
   .master_clock_present, .loop_global_enable, .select_pin, .freq_over_limit, .fast_avg_done, .slow_avg_done,
   .selected_reference, .loop_state_code, .active_bandwidth, .wide_tracking_range, .holdover_history_clear,
   .fast_holdover_ready, .slow_holdover_ready);
`default_nettype wire
